// [cie_top.v]
// cpu interrupt entry sequencer with source qualification
`timescale 1ns/1ps
`default_nettype none
module cie_top
(
   input wire clock_i,
   input wire srst_i,
   input wire ce_i,
   input wire [7:0] event_i,
   input wire [7:0] flag_clr_i,
   input wire [7:0] enable_i,
   input wire instr_done_i,
   input wire swi_i,
   input wire rti_i,
   input wire [7:0] rti_ccr_i,
   input wire mask_set_i,
   input wire mask_clr_i,
   input wire [15:0] pc_i,
   input wire [7:0] x_i,
   input wire [7:0] a_i,
   input wire [7:0] ccr_i,
   input wire [15:0] sp_i,
   input wire [7:0] mem_rdata_i,
   output wire [7:0] flag_o,
   output reg irq_pending_o,
   output reg imask_o,
   output reg busy_o,
   output reg [15:0] mem_addr_o,
   output reg [7:0] mem_wdata_o,
   output reg mem_wr_o,
   output reg mem_rd_o,
   output reg [15:0] sp_o,
   output reg sp_load_o,
   output reg [15:0] pc_o,
   output reg [7:0] queue0_o,
   output reg [7:0] queue1_o,
   output reg [7:0] queue2_o,
   output reg queue_valid_o
);
`include "cie_consts.vh"
   // ****************************************
   // states
   // ****************************************
   localparam [5:0] S_IDLE = 6'b00_0001;
   localparam [5:0] S_PUSH = 6'b00_0010;
   localparam [5:0] S_VHI = 6'b00_0100;
   localparam [5:0] S_VLO = 6'b00_1000;
   localparam [5:0] S_FILL = 6'b01_0000;
   localparam [5:0] S_END = 6'b10_0000;

   wire [7:0] req;
   reg [5:0] state_reg;
   reg [5:0] state_next;
   reg [2:0] cnt_reg;
   reg [2:0] cnt_next;
   reg swi_reg;
   reg swi_next;
   reg [15:0] sp_reg;
   reg [15:0] sp_next;
   reg [7:0] vhi_reg;
   reg [7:0] vhi_next;
   reg [15:0] vec_reg;
   reg [15:0] vec_next;
   reg [15:0] fill_reg;
   reg [15:0] fill_next;
   reg [2:0] top_src;
   reg any_req;
   integer i;

   // ****************************************
   // source flags
   // ****************************************
   cie_flag_bank u_flags
   (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .event_i(event_i),
      .flag_clr_i(flag_clr_i),
      .enable_i(enable_i),
      .flag_o(flag_o),
      .req_o(req)
   );

   // higher index wins, as sources nearer the bottom rank higher
   always @*
   begin
      top_src = 3'h0;
      any_req = 1'b0;
      for (i = 0; i < `CIE_NSRC; i = i + 1)
      begin
         if (req[i])
         begin
            top_src = i[2:0];
            any_req = 1'b1;
         end
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always @*
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      swi_next = swi_reg;
      sp_next = sp_reg;
      vhi_next = vhi_reg;
      vec_next = vec_reg;
      fill_next = fill_reg;
      case (state_reg)
         S_IDLE:
         begin
            // only at a boundary; swi shares the whole path
            if (instr_done_i && (swi_i || (any_req && !imask_o)))
            begin
               state_next = S_PUSH;
               swi_next = swi_i;
               sp_next = sp_i;
               cnt_next = 3'h0;
            end
         end
         S_PUSH:
         begin
            sp_next = sp_reg - 16'h0001;
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `CIE_PUSH_N - 3'h1)
               state_next = S_VHI;
         end
         S_VHI:
         begin
            // pick the vector now, not at entry, so late arrivals win
            if (swi_reg || !any_req)
               vec_next = `CIE_VEC_SWI;
            else
               vec_next = `CIE_VEC_SRC0 - {12'h000, top_src, 1'b0};
            state_next = S_VLO;
         end
         S_VLO:
         begin
            state_next = S_FILL;
            cnt_next = 3'h0;
         end
         S_FILL:
         begin
            // read data trail the strobe by one cycle
            if (cnt_reg == 3'h1)
               vhi_next = mem_rdata_i;
            if (cnt_reg == 3'h2)
               fill_next = {vhi_reg, mem_rdata_i};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == {1'b0, `CIE_FILL_N} + 3'h2)
               state_next = S_END;
         end
         S_END:
         begin
            state_next = S_IDLE;
         end
         default:
         begin
            state_next = S_IDLE;
         end
      endcase
   end

   // ****************************************
   // registers and outputs
   // ****************************************
   always @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state_reg <= S_IDLE;
         cnt_reg <= 3'h0;
         swi_reg <= 1'b0;
         sp_reg <= 16'h0000;
         vhi_reg <= 8'h00;
         vec_reg <= 16'h0000;
         fill_reg <= 16'h0000;
         irq_pending_o <= 1'b0;
         imask_o <= `CIE_IMASK_RST;
         busy_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         mem_wdata_o <= 8'h00;
         mem_wr_o <= 1'b0;
         mem_rd_o <= 1'b0;
         sp_o <= 16'h0000;
         sp_load_o <= 1'b0;
         pc_o <= 16'h0000;
         queue0_o <= 8'h00;
         queue1_o <= 8'h00;
         queue2_o <= 8'h00;
         queue_valid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         swi_reg <= swi_next;
         sp_reg <= sp_next;
         vhi_reg <= vhi_next;
         vec_reg <= vec_next;
         fill_reg <= fill_next;
         irq_pending_o <= any_req & ~imask_o;
         busy_o <= (state_next != S_IDLE);
         mem_wr_o <= 1'b0;
         mem_rd_o <= 1'b0;
         sp_load_o <= 1'b0;
         queue_valid_o <= 1'b0;
         if (state_reg == S_PUSH)
         begin
            mem_wr_o <= 1'b1;
            mem_addr_o <= sp_reg;
            case (cnt_reg)
               3'h0: mem_wdata_o <= pc_i[7:0];
               3'h1: mem_wdata_o <= pc_i[15:8];
               3'h2: mem_wdata_o <= x_i;
               3'h3: mem_wdata_o <= a_i;
               default:
               begin
                  mem_wdata_o <= ccr_i;
                  mem_wdata_o[`CIE_CCR_I_BIT] <= imask_o;
               end
            endcase
         end
         if (state_reg == S_VHI)
         begin
            imask_o <= 1'b1;
            sp_o <= sp_reg;
            sp_load_o <= 1'b1;
         end
         else if (state_reg == S_IDLE && rti_i)
            imask_o <= rti_ccr_i[`CIE_CCR_I_BIT];
         else if (state_reg == S_IDLE && mask_set_i)
            imask_o <= 1'b1;
         else if (state_reg == S_IDLE && mask_clr_i)
            imask_o <= 1'b0;
         if (state_reg == S_VLO)
         begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= vec_reg;
         end
         if (state_reg == S_FILL)
         begin
            case (cnt_reg)
               3'h0:
               begin
                  mem_rd_o <= 1'b1;
                  mem_addr_o <= vec_reg + 16'h0001;
               end
               3'h2:
               begin
                  mem_rd_o <= 1'b1;
                  mem_addr_o <= {vhi_reg, mem_rdata_i};
               end
               3'h3:
               begin
                  mem_rd_o <= 1'b1;
                  mem_addr_o <= fill_reg + 16'h0001;
               end
               3'h4:
               begin
                  mem_rd_o <= 1'b1;
                  mem_addr_o <= fill_reg + 16'h0002;
                  queue0_o <= mem_rdata_i;
               end
               default:
               begin
                  if (cnt_reg == 3'h5)
                     queue1_o <= mem_rdata_i;
               end
            endcase
         end
         if (state_reg == S_END)
         begin
            queue2_o <= mem_rdata_i;
            pc_o <= fill_reg;
            queue_valid_o <= 1'b1;
         end
      end
   end
endmodule // cie_top
`default_nettype wire

// [cie_consts.vh]
// constants for the cpu interrupt entry block
`ifndef CIE_CONSTS_VH
`define CIE_CONSTS_VH
`define CIE_NSRC 8
`define CIE_SRC_W 3
`define CIE_CCR_I_BIT 3
`define CIE_VEC_SWI 16'hFFFC
`define CIE_VEC_SRC0 16'hFFFA
`define CIE_PUSH_N 3'h5
`define CIE_FILL_N 2'h3
`define CIE_CCR_RST 8'hFF
`define CIE_IMASK_RST 1'b1
`endif

// [cie_flag_bank.v]
// per-source status flags and local enable gating
`timescale 1ns/1ps
`default_nettype none
module cie_flag_bank
(
   input wire clock_i,
   input wire srst_i,
   input wire ce_i,
   input wire [7:0] event_i,
   input wire [7:0] flag_clr_i,
   input wire [7:0] enable_i,
   output reg [7:0] flag_o,
   output reg [7:0] req_o
);
`include "cie_consts.vh"
   genvar g;
   generate
      for (g = 0; g < `CIE_NSRC; g = g + 1)
      begin : g_src
         wire flag_next;
         // set beats clear so an event during clear is kept
         assign flag_next = event_i[g] | (flag_o[g] & ~flag_clr_i[g]);
         always @(posedge clock_i)
         begin
            if (srst_i)
            begin
               flag_o[g] <= 1'b0;
               req_o[g] <= 1'b0;
            end
            else if (ce_i)
            begin
               flag_o[g] <= flag_next;
               req_o[g] <= flag_next & enable_i[g];
            end
         end
      end
   endgenerate
endmodule // cie_flag_bank
`default_nettype wire

// [cie_top_properties.sv]
// checker for the interrupt entry sequencer
`timescale 1ns/1ps
`default_nettype none
module cie_top_properties
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic instr_done_i,
   input wire logic swi_i,
   input wire logic [7:0] event_i,
   input wire logic [15:0] sp_i,
   input wire logic [7:0] flag_o,
   input wire logic irq_pending_o,
   input wire logic imask_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic [15:0] sp_o,
   input wire logic sp_load_o,
   input wire logic queue_valid_o
);
   // ****
   // properties
   // ****
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   reset_mask_a: assert property (disable iff (1'b0)
      srst_i |=> imask_o) else $error("mask not set by reset");
   flag_set_a: assert property (
      ce_i && |event_i |=> (flag_o & $past(event_i)) == $past(event_i))
      else $error("event did not set flag");
   masked_idle_a: assert property (imask_o |=> !irq_pending_o)
      else $error("request pending while masked");
   push_five_a: assert property (
      $rose(mem_wr_o) |-> mem_wr_o [*5] ##1 !mem_wr_o)
      else $error("push count wrong");
   stack_mask_a: assert property (
      sp_load_o |-> imask_o && sp_o == sp_i - 16'h0005)
      else $error("mask or stack pointer wrong");
   vec_pair_a: assert property (
      sp_load_o |=> mem_rd_o && mem_addr_o[15:8] == 8'hff ##1
      mem_rd_o && mem_addr_o == $past(mem_addr_o) + 16'h0001)
      else $error("vector read pair wrong");
   fill_three_a: assert property (
      queue_valid_o |-> $past(mem_rd_o, 2) && $past(mem_rd_o, 3)
      && $past(mem_rd_o, 4) && !$past(mem_rd_o))
      else $error("queue not filled by three reads");
   entry_time_a: assert property (
      $rose(mem_wr_o) |-> ##13 queue_valid_o)
      else $error("entry length wrong");
   start_qual_a: assert property (
      $rose(mem_wr_o) |-> $past(instr_done_i, 2)
      && ($past(swi_i, 2) || !$past(imask_o, 2)))
      else $error("entry without qualified request");
   cover property ($rose(mem_wr_o) && $past(swi_i, 2));
   cover property (sp_load_o ##8 queue_valid_o);
   cover property (imask_o ##1 !imask_o);
endmodule // cie_top_properties
bind cie_top cie_top_properties chk_u (.*);
`default_nettype wire

// [cie_mem_model.sv]
// memory answering reads one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module cie_mem_model
(
   input wire logic clock_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] mem_addr_i,
   output logic [7:0] mem_rdata_o
);
   initial mem_rdata_o = 8'h00;
   // idle data toggles so a sample one cycle late does not match
   always @(posedge clock_i)
   begin
      if (mem_rd_i)
         mem_rdata_o <= mem_addr_i[7:0] ^ 8'h3c;
      else
         mem_rdata_o <= ~mem_rdata_o;
   end
endmodule // cie_mem_model
`default_nettype wire

// [tb_cie_top.sv]
// self-checking bench for the interrupt entry sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_cie_top;
   logic clock_i, srst_i, ce_i, instr_done_i, swi_i, rti_i;
   logic mask_set_i, mask_clr_i, irq_pending_o, imask_o, busy_o;
   logic mem_wr_o, mem_rd_o, sp_load_o, queue_valid_o;
   logic [7:0] event_i, flag_clr_i, enable_i, rti_ccr_i, flag_o, x_i;
   logic [7:0] a_i, ccr_i, mem_rdata_i, mem_wdata_o;
   logic [7:0] queue0_o, queue1_o, queue2_o;
   logic [15:0] pc_i, sp_i, mem_addr_o, sp_o, pc_o;
   int failures, cmp_count;
   cie_top dut_u (.*);
   cie_mem_model mem_u (.clock_i(clock_i), .mem_rd_i(mem_rd_o),
      .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task tick;
   begin
      @(posedge clock_i);
      #1;
   end
   endtask
   task give_verdict;
   begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
   begin
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   end
   endtask
   function logic [7:0] mb(input logic [15:0] a);
      mb = a[7:0] ^ 8'h3c;
   endfunction
   // ****
   // one-cycle strobes: done, swi, rti, set, clr
   // ****
   task cmd(input logic [4:0] c, input logic [7:0] e, input logic [7:0] f);
   begin
      {instr_done_i, swi_i, rti_i, mask_set_i, mask_clr_i} = c;
      event_i = e;
      flag_clr_i = f;
      tick;
      {instr_done_i, swi_i, rti_i, mask_set_i, mask_clr_i} = 5'h00;
      event_i = 8'h00;
      flag_clr_i = 8'h00;
      repeat (2) tick;
   end
   endtask
   task entry(input logic [4:0] c, input logic [15:0] v, input logic im);
      logic [7:0] wd [0:4];
      logic [15:0] np;
      int w, r, n;
   begin
      wd = '{pc_i[7:0], pc_i[15:8], x_i, a_i, ccr_i | {4'h0, im, 3'h0}};
      np = {mb(v), mb(v + 16'h0001)};
      w = 0;
      r = 0;
      {instr_done_i, swi_i, rti_i, mask_set_i, mask_clr_i} = c;
      tick;
      {instr_done_i, swi_i, rti_i, mask_set_i, mask_clr_i} = 5'h00;
      for (n = 0; n < 30 && queue_valid_o !== 1'b1; n++)
      begin
         if (mem_wr_o === 1'b1)
         begin
            chk("push", {mem_addr_o, mem_wdata_o},
               {sp_i - 16'(w), wd[w]});
            w++;
         end
         if (mem_rd_o === 1'b1)
         begin
            chk("read", mem_addr_o,
               r < 2 ? v + 16'(r) : np + 16'(r - 2));
            r++;
         end
         tick;
      end
      if (queue_valid_o !== 1'b1)
      begin
         failures++;
         give_verdict;
      end
      chk("count", {w[7:0], r[7:0]}, 16'h0505);
      chk("pc", pc_o, np);
      chk("queue", {queue0_o, queue1_o, queue2_o},
         {mb(np), mb(np + 16'h0001), mb(np + 16'h0002)});
      chk("mask", imask_o, 1'b1);
   end
   endtask
   task t_gate;
   begin
      enable_i = 8'h04;
      cmd(5'h00, 8'h04, 8'h00);
      cmd(5'h10, 8'h00, 8'h00);
      chk("gate", {flag_o, irq_pending_o, busy_o}, 10'h010);
      enable_i = 8'h00;
      cmd(5'h01, 8'h00, 8'h00);
      chk("pend", {imask_o, irq_pending_o}, 2'b00);
      enable_i = 8'h04;
      repeat (2) tick;
      chk("pend", irq_pending_o, 1'b1);
      cmd(5'h00, 8'h00, 8'h04);
      tick;
      chk("clr", {flag_o, irq_pending_o}, 9'h000);
      ce_i = 1'b0;
      cmd(5'h00, 8'h04, 8'h00);
      chk("freeze", flag_o, 8'h00);
      ce_i = 1'b1;
   end
   endtask
   task t_swi;
   begin
      cmd(5'h02, 8'h00, 8'h00);
      entry(5'h18, 16'hfffc, 1'b1);
      cmd(5'h04, 8'h00, 8'h00);
      chk("ret", imask_o, 1'b0);
   end
   endtask
   task t_prio;
   begin
      enable_i = 8'h22;
      ccr_i = 8'h01;
      cmd(5'h00, 8'h22, 8'h00);
      entry(5'h10, 16'hfff0, 1'b0);
      cmd(5'h00, 8'h00, 8'h20);
      cmd(5'h00, 8'h20, 8'h00);
      chk("held", flag_o, 8'h22);
      cmd(5'h04, 8'h00, 8'h00);
      chk("ret", {imask_o, irq_pending_o}, 2'b01);
   end
   endtask
   initial
   begin
      srst_i = 1'b1;
      ce_i = 1'b1;
      {instr_done_i, swi_i, rti_i, mask_set_i, mask_clr_i} = 5'h00;
      {event_i, flag_clr_i, enable_i, rti_ccr_i, ccr_i} = 40'h00_0000_0000;
      pc_i = 16'h1234;
      sp_i = 16'h01ff;
      x_i = 8'h56;
      a_i = 8'h78;
      failures = 0;
      cmp_count = 0;
      repeat (6) tick;
      srst_i = 1'b0;
      chk("reset", {flag_o, imask_o, busy_o}, 10'h002);
      t_gate;
      t_swi;
      t_prio;
      give_verdict;
   end
endmodule // tb_cie_top
`default_nettype wire
